// >>> hdl/eba_pkg.sv
// Shared constants and types for the endpoint buffer access path
package eba_pkg;
  // Endpoint count and buffer geometry
  localparam int        EBA_EPS       = 16;
  localparam int        EBA_N_BYTES   = 32;
  localparam int        EBA_HDR_BYTES = 2;
  localparam int        EBA_PTR_W     = 6;
  localparam int        EBA_DATA_W    = 16;
  // Command code groups (upper nibble) and excluded write and read codes
  localparam logic [3:0] EBA_GRP_WR   = 4'h0;
  localparam logic [3:0] EBA_GRP_RD   = 4'h1;
  localparam logic [3:0] EBA_GRP_STAT = 4'h5;
  localparam logic [3:0] EBA_WR_NONE  = 4'h0;
  localparam logic [3:0] EBA_RD_NONE  = 4'h1;
  // Status byte layout
  localparam int        EBA_ST_STALL  = 7;
  localparam int        EBA_ST_FULL1  = 6;
  localparam int        EBA_ST_FULL0  = 5;
  localparam int        EBA_ST_TOGGLE = 4;
  localparam int        EBA_ST_OVRUN  = 3;
  localparam int        EBA_ST_SETUP  = 2;
  localparam int        EBA_ST_CPUSEL = 1;
  localparam logic [7:0] EBA_ST_RESET = 8'h00;
  // Pointer steps per data phase
  localparam logic [EBA_PTR_W-1:0] EBA_STEP8  = 6'h01;
  localparam logic [EBA_PTR_W-1:0] EBA_STEP16 = 6'h02;
  localparam logic [EBA_PTR_W-1:0] EBA_PTR0   = 6'h00;
  // Access mode after a command
  typedef enum logic [1:0] {
    EBA_MODE_IDLE,
    EBA_MODE_WR,
    EBA_MODE_RD,
    EBA_MODE_STAT
  } eba_mode_t;
endpackage

// >>> hdl/eba_bus_if.sv
// Parallel command/data bus between host and endpoint buffer device
`timescale 1ns/1ps
interface eba_bus_if;
  import eba_pkg::*;
  logic                  bus_stb;
  logic                  bus_we;
  logic                  cmd_data_select;
  logic                  bus_wide;
  logic                  bus_dma;
  logic                  transfer_end;
  logic [EBA_DATA_W-1:0] host_data;
  logic                  host_oe_n;
  logic                  bus_ready;
  logic [EBA_DATA_W-1:0] dev_data;
  logic                  dev_oe_n;
  logic                  dev_valid;
  logic                  eop;
  modport dev (
    input  bus_stb, bus_we, cmd_data_select, bus_wide, bus_dma,
    input  transfer_end, host_data, host_oe_n,
    output bus_ready, dev_data, dev_oe_n, dev_valid, eop
  );
  modport host (
    output bus_stb, bus_we, cmd_data_select, bus_wide, bus_dma,
    output transfer_end, host_data, host_oe_n,
    input  bus_ready, dev_data, dev_oe_n, dev_valid, eop
  );
endinterface

// >>> hdl/eba_device.sv
// Device end: endpoint buffers, pointer, write FIFO and status byte
`timescale 1ns/1ps
module eba_fifo
  import eba_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clocking
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  wire              push = ce & in_valid & in_ready;
  wire              pop  = ce & out_valid & out_ready;

  // Honest full and empty from extended pointers
  assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign out_data  = mem[rd_reg[AW-1:0]];

  // Storage and pointers
  always_ff @(posedge core_clk) begin
    if (push) mem[wr_reg[AW-1:0]] <= in_data;
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// Contract
// [RULE1] Buffer command rewinds pointer to start
// [RULE2] Host moves at most N+2 bytes
// [RULE3] Pointer steps one byte or two
// [RULE4] DMA skips the two-byte length header
// [RULE5] Reads flag last byte with end-of-packet
// [RULE6] Bulk IN buffers sent only when full
// [RULE7] Transfer end sends partial DMA write buffer
// [RULE8] No reads after write command, nor reverse
// [RULE9] Decode buffer write and read codes
// [RULE10] Host sizes buffers to 1023 or 32
// [RULE11] Length header low first, bytes paired low-high
// [RULE12] Command phase select high, low byte only
// [RULE13] Host avoids overruns and wrong-direction access
// [RULE14] DMA rolls into secondary buffer at end
// [RULE15] Codes 50-5F return one status byte
// [RULE16] Status read clears interrupt; bits read-only
// [RULE17] Stall bit set, cleared, cleared by SETUP
// [RULE18] Bits 6 and 5 show buffers full
// [RULE19] Bit 4 shows next data toggle
// [RULE20] Setup overrun flag, cleared by read; eba_device keeps it set on a status read while usb_setup_busy is high
// [RULE21] Host abandons setup on overrun flag; eba_host only returns the status byte and never checks bit 3
// [RULE22] Setup held, CPU buffer select, bit 0 reserved
// [RULE23] IN buffers transmit, OUT buffers receive
module eba_device
  import eba_pkg::*;
#(
  parameter int                BUF_BYTES  = EBA_N_BYTES + EBA_HDR_BYTES,
  parameter logic [EBA_EPS-1:0] DOUBLE_BUF = 16'h0000,
  parameter int                FIFO_DEPTH = 16
) (
  // Clocking
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Host bus
  eba_bus_if.dev                bus,
  // Serial engine events
  input  wire logic [3:0]       usb_ep,
  input  wire logic             usb_buf,
  input  wire logic             usb_rx_done,
  input  wire logic             usb_tx_done,
  input  wire logic             usb_setup,
  input  wire logic             usb_setup_busy,
  input  wire logic             usb_toggle,
  input  wire logic             stall_set,
  input  wire logic             stall_clr,
  // Serial engine buffer read port
  input  wire logic             usb_rd_en,
  input  wire logic [EBA_PTR_W-1:0] usb_rd_ptr,
  output logic [7:0]            usb_rd_data,
  // Transmit and interrupt handoff
  output logic                  tx_req,
  output logic [3:0]            tx_ep,
  output logic                  int_clear,
  output logic [3:0]            int_clear_ep
);
  localparam int AW = 4 + 1 + EBA_PTR_W;
  localparam int FW = AW + EBA_DATA_W + 1;
  localparam logic [EBA_PTR_W-1:0] END_PTR = EBA_PTR_W'(BUF_BYTES);
  localparam logic [EBA_PTR_W-1:0] HDR_PTR = EBA_PTR_W'(EBA_HDR_BYTES);

  function automatic logic [EBA_EPS-1:0] ep_hot(input logic [3:0] ep);
    ep_hot = EBA_EPS'(1) << ep;
  endfunction

  logic [7:0]           mem [2**AW];
  eba_mode_t            mode_reg;
  logic [3:0]           ep_reg;
  logic [EBA_PTR_W-1:0] ptr_reg;
  logic [EBA_EPS-1:0]   stall_reg, full0_reg, full1_reg, toggle_reg;
  logic [EBA_EPS-1:0]   ovrun_reg, setup_reg, cpusel_reg, txpend_reg;
  logic [EBA_DATA_W-1:0] rdata_reg;
  logic                 dvalid_reg, eop_reg, intclr_reg;
  logic [3:0]           intclr_ep_reg;
  logic [7:0]           usb_rd_reg;
  logic                 fifo_in_ready, fifo_out_valid;
  logic [FW-1:0]        fifo_out;

  // Command decode on the low byte only
  wire [7:0] code    = bus.host_data[7:0];                          // [RULE12]
  wire       c_wr    = code[7:4] == EBA_GRP_WR && code[3:0] != EBA_WR_NONE;
  wire       c_rd    = code[7:4] == EBA_GRP_RD && code[3:0] != EBA_RD_NONE;
  wire       c_st    = code[7:4] == EBA_GRP_STAT;                   // [RULE15]
  wire       f_empty = !fifo_out_valid;

  // Bus ready: commands and reads wait for pending writes
  assign bus.bus_ready = (bus.cmd_data_select || mode_reg != EBA_MODE_WR)
                         ? f_empty : fifo_in_ready;
  wire acc    = ce & bus.bus_stb & bus.bus_ready;
  wire acc_c  = acc & bus.cmd_data_select;
  wire acc_d  = acc & !bus.cmd_data_select;
  wire acc_wr = acc_d & bus.bus_we & mode_reg == EBA_MODE_WR;
  wire acc_rd = acc_d & !bus.bus_we & mode_reg == EBA_MODE_RD;
  wire acc_st = acc_d & !bus.bus_we & mode_reg == EBA_MODE_STAT;

  // Effective pointer, step and wrap handling
  wire       cur_buf = cpusel_reg[ep_reg];
  wire [EBA_PTR_W-1:0] step = bus.bus_wide ? EBA_STEP16 : EBA_STEP8; // [RULE3]
  wire [EBA_PTR_W-1:0] ptr_eff = (bus.bus_dma && ptr_reg < HDR_PTR)
                                 ? HDR_PTR : ptr_reg;                // [RULE4]
  wire [EBA_PTR_W-1:0] ptr_adv = ptr_eff + step;
  wire       at_end  = ptr_adv >= END_PTR;
  wire       dbl_sw  = bus.bus_dma & DOUBLE_BUF[ep_reg] & at_end;   // [RULE14]
  wire [AW-1:0] addr = {ep_reg, cur_buf, ptr_eff};
  wire [AW-1:0] hdr0 = {ep_reg, cur_buf, EBA_PTR0};
  wire [15:0] pkt_len = {mem[hdr0 + AW'(1)], mem[hdr0]};            // [RULE11]
  wire       last_rd = 16'(ptr_adv) >= pkt_len + 16'(EBA_HDR_BYTES);

  // Buffer completion on a write: full, or cut short by transfer end during DMA
  wire       wr_done = (acc_wr & at_end)                            // [RULE6]
                     | (ce & bus.transfer_end & bus.bus_dma
                        & mode_reg == EBA_MODE_WR);                 // [RULE7]
  wire [EBA_EPS-1:0] done_m = wr_done ? ep_hot(ep_reg) : '0;
  wire [EBA_EPS-1:0] done0  = cur_buf ? '0 : done_m;
  wire [EBA_EPS-1:0] done1  = cur_buf ? done_m : '0;

  // Serial engine event masks, plus status-read, buffer-switch and transmit-select masks
  wire [EBA_EPS-1:0] u_m   = ep_hot(usb_ep);
  wire [EBA_EPS-1:0] rx0   = (ce & usb_rx_done & !usb_buf) ? u_m : '0;
  wire [EBA_EPS-1:0] rx1   = (ce & usb_rx_done & usb_buf) ? u_m : '0;
  wire [EBA_EPS-1:0] tx0   = (ce & usb_tx_done & !usb_buf) ? u_m : '0;
  wire [EBA_EPS-1:0] tx1   = (ce & usb_tx_done & usb_buf) ? u_m : '0;
  wire [EBA_EPS-1:0] sup_m = (ce & usb_setup) ? u_m : '0;
  wire [EBA_EPS-1:0] tog_m = (ce & usb_toggle) ? u_m : '0;
  wire [EBA_EPS-1:0] sst_m = (ce & stall_set) ? u_m : '0;
  wire [EBA_EPS-1:0] scl_m = (ce & stall_clr) ? u_m : '0;
  wire [EBA_EPS-1:0] st_m  = acc_st ? ep_hot(ep_reg) : '0;
  wire [EBA_EPS-1:0] ovc_m = usb_setup_busy ? '0 : st_m;
  wire [EBA_EPS-1:0] sw_m  = (acc_d & dbl_sw) ? ep_hot(ep_reg) : '0;
  wire       tx_pend_any = |txpend_reg;
  wire [EBA_EPS-1:0] txs_m = (fifo_out_valid || !tx_pend_any || !ce) ? '0
                             : (txpend_reg & -txpend_reg);

  // Status byte of the addressed endpoint, bit 0 reserved as zero
  wire [7:0] status_b;                                              // [RULE22]
  assign status_b[EBA_ST_STALL]  = stall_reg[ep_reg];               // [RULE17]
  assign status_b[EBA_ST_FULL1]  = full1_reg[ep_reg];               // [RULE18]
  assign status_b[EBA_ST_FULL0]  = full0_reg[ep_reg];               // [RULE18]
  assign status_b[EBA_ST_TOGGLE] = toggle_reg[ep_reg];              // [RULE19]
  assign status_b[EBA_ST_OVRUN]  = ovrun_reg[ep_reg];               // [RULE20]
  assign status_b[EBA_ST_SETUP]  = setup_reg[ep_reg];               // [RULE22]
  assign status_b[EBA_ST_CPUSEL] = cpusel_reg[ep_reg];              // [RULE22]
  assign status_b[0]             = 1'b0;

  // Read data: header and paired data bytes, low byte first
  wire [15:0] rd_word = bus.bus_wide ? {mem[addr + AW'(1)], mem[addr]}
                                     : {8'h00, mem[addr]};          // [RULE11]

  eba_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (acc_wr),
    .in_ready  (fifo_in_ready),
    .in_data   ({bus.bus_wide, addr, bus.host_data}),
    .out_valid (fifo_out_valid),
    .out_ready (!usb_rd_en),
    .out_data  (fifo_out)
  );
  wire          f_wide = fifo_out[FW-1];
  wire [AW-1:0] f_addr = fifo_out[EBA_DATA_W +: AW];
  wire          f_pop  = ce & fifo_out_valid & !usb_rd_en;

  // Buffer memory: drained writes and serial engine reads
  always_ff @(posedge core_clk) begin
    if (f_pop) begin
      mem[f_addr] <= fifo_out[7:0];
      if (f_wide) mem[f_addr + AW'(1)] <= fifo_out[15:8];
    end
    if (ce && usb_rd_en) usb_rd_reg <= mem[{usb_ep, usb_buf, usb_rd_ptr}];
  end
  assign usb_rd_data = usb_rd_reg;

  // Command mode, endpoint and pointer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg <= EBA_MODE_IDLE;
      ep_reg   <= 4'h0;
      ptr_reg  <= EBA_PTR0;
    end else if (acc_c) begin
      mode_reg <= c_wr ? EBA_MODE_WR : c_rd ? EBA_MODE_RD
                : c_st ? EBA_MODE_STAT : EBA_MODE_IDLE;             // [RULE9]
      ep_reg   <= code[3:0];
      ptr_reg  <= EBA_PTR0;                                         // [RULE1]
    end else if (acc_wr || acc_rd) begin
      ptr_reg  <= dbl_sw ? EBA_PTR0 : ptr_adv;                      // [RULE3]
    end
  end

  // Per-endpoint status; every set wins over its clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      {stall_reg, full0_reg, full1_reg, toggle_reg} <= '0;
      {ovrun_reg, setup_reg, cpusel_reg, txpend_reg} <= '0;
    end else begin
      stall_reg  <= (stall_reg & ~scl_m & ~sup_m) | sst_m;          // [RULE17]
      full0_reg  <= (full0_reg & ~tx0) | rx0 | done0;               // [RULE23]
      full1_reg  <= (full1_reg & ~tx1) | rx1 | done1;               // [RULE18]
      toggle_reg <= toggle_reg ^ tog_m;                             // [RULE19]
      ovrun_reg  <= (ovrun_reg & ~ovc_m) | (sup_m & setup_reg);     // [RULE20]
      setup_reg  <= setup_reg | sup_m;                              // [RULE22]
      cpusel_reg <= cpusel_reg ^ sw_m;                              // [RULE14]
      txpend_reg <= (txpend_reg & ~txs_m) | done_m;                 // [RULE6]
    end
  end

  // Read answers, end-of-packet and interrupt clear strobes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg     <= '0;
      dvalid_reg    <= 1'b0;
      eop_reg       <= 1'b0;
      intclr_reg    <= 1'b0;
      intclr_ep_reg <= 4'h0;
      tx_req        <= 1'b0;
      tx_ep         <= 4'h0;
    end else if (ce) begin
      dvalid_reg    <= acc_rd | acc_st;
      eop_reg       <= acc_rd & last_rd;                            // [RULE5]
      intclr_reg    <= acc_st;                                      // [RULE16]
      tx_req        <= |txs_m;                                      // [RULE6]
      if (|txs_m) tx_ep <= usb_ep_of(txs_m);
      if (acc_st) intclr_ep_reg <= ep_reg;
      if (acc_rd) rdata_reg <= rd_word;
      else if (acc_st) rdata_reg <= {8'h00, status_b};              // [RULE15]
    end
  end

  function automatic logic [3:0] usb_ep_of(input logic [EBA_EPS-1:0] m);
    usb_ep_of = 4'h0;
    for (int i = 0; i < EBA_EPS; i++)
      if (m[i]) usb_ep_of = 4'(i);
  endfunction

  assign bus.dev_data  = rdata_reg;
  assign bus.dev_oe_n  = !dvalid_reg;
  assign bus.dev_valid = dvalid_reg;
  assign bus.eop       = eop_reg;
  assign int_clear     = intclr_reg;
  assign int_clear_ep  = intclr_ep_reg;
endmodule

// >>> hdl/eba_host.sv
// Host end: issues commands and data phases, keeps the host-side limits
`timescale 1ns/1ps
module eba_host
  import eba_pkg::*;
#(
  parameter int N_BYTES = EBA_N_BYTES
) (
  // Clocking
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Configuration
  input  wire logic             u_wide,
  input  wire logic             u_dma,
  // User requests
  input  wire logic             u_cmd_valid,
  input  wire logic [7:0]       u_cmd,
  input  wire logic             u_wr_valid,
  input  wire logic [EBA_DATA_W-1:0] u_wr_data,
  input  wire logic             u_rd_valid,
  input  wire logic             u_end,
  output logic                  u_ready,
  output logic                  u_error,
  // User answers
  output logic [EBA_DATA_W-1:0] u_rd_data,
  output logic                  u_rd_data_valid,
  output logic                  u_eop,
  // Device bus
  eba_bus_if.host               bus
);
  localparam logic [9:0] LIM8  = 10'(N_BYTES + EBA_HDR_BYTES);
  localparam logic [9:0] LIM16 = 10'((N_BYTES + 1) / 2 + 1);
  localparam logic [9:0] LIMST = 10'h001;

  eba_mode_t  mode_reg;
  logic [9:0] cnt_reg;
  logic       err_reg;
  logic [EBA_DATA_W-1:0] rd_reg;
  logic       rdv_reg, eop_reg;

  // Limits and direction checks before driving the bus
  wire [9:0] lim    = mode_reg == EBA_MODE_STAT ? LIMST
                    : u_wide ? LIM16 : LIM8;                        // [RULE2]
  wire room         = cnt_reg < lim;                                // [RULE13]
  wire wr_ok  = mode_reg == EBA_MODE_WR && room;                    // [RULE8]
  wire rd_ok  = (mode_reg == EBA_MODE_RD || mode_reg == EBA_MODE_STAT)
                && room;                                            // [RULE8]
  wire bad    = (u_wr_valid && !wr_ok) || (u_rd_valid && !rd_ok);
  wire go     = u_cmd_valid || (u_wr_valid && wr_ok)
                || (u_rd_valid && rd_ok);

  // Command on the low byte with select high, data with it low
  assign bus.bus_stb         = go;
  assign bus.bus_we          = u_cmd_valid || u_wr_valid;
  assign bus.cmd_data_select = u_cmd_valid;                         // [RULE12]
  assign bus.host_data       = u_cmd_valid ? {8'h00, u_cmd} : u_wr_data;
  assign bus.host_oe_n       = !(u_cmd_valid || u_wr_valid);
  assign bus.bus_wide        = u_wide;
  assign bus.bus_dma         = u_dma;
  assign bus.transfer_end    = u_end & ce;
  assign u_ready             = bad ? 1'b1 : bus.bus_ready;
  assign u_error             = err_reg;
  assign u_rd_data           = rd_reg;
  assign u_rd_data_valid     = rdv_reg;
  assign u_eop               = eop_reg;

  // Mode and transfer count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg <= EBA_MODE_IDLE;
      cnt_reg  <= '0;
      err_reg  <= 1'b0;
    end else if (ce) begin
      err_reg <= bad;
      if (u_cmd_valid && bus.bus_ready) begin
        cnt_reg  <= '0;
        mode_reg <= u_cmd[7:4] == EBA_GRP_WR ? EBA_MODE_WR
                  : u_cmd[7:4] == EBA_GRP_RD ? EBA_MODE_RD
                  : u_cmd[7:4] == EBA_GRP_STAT ? EBA_MODE_STAT
                  : EBA_MODE_IDLE;                                  // [RULE6]
      end else if (go && !u_cmd_valid && bus.bus_ready) begin
        cnt_reg <= cnt_reg + 10'h001;                               // [RULE10]
      end
    end
  end

  // Capture returned data, status and end-of-packet
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_reg  <= '0;
      rdv_reg <= 1'b0;
      eop_reg <= 1'b0;
    end else if (ce) begin
      rdv_reg <= bus.dev_valid;
      eop_reg <= bus.eop;
      if (bus.dev_valid) rd_reg <= bus.dev_data;                    // [RULE21]
    end
  end
endmodule

// >>> verif/eba_props.sv
// Concurrent checks on the host/device command and data bus
`timescale 1ns/1ps
module eba_props
  import eba_pkg::*;
(
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst,
  // Host requests
  input wire logic                  bus_stb,
  input wire logic                  bus_we,
  input wire logic                  cmd_data_select,
  input wire logic                  bus_wide,
  input wire logic                  bus_dma,
  input wire logic                  transfer_end,
  input wire logic [EBA_DATA_W-1:0] host_data,
  input wire logic                  host_oe_n,
  // Device answers
  input wire logic                  bus_ready,
  input wire logic                  dev_oe_n,
  input wire logic                  dev_valid,
  input wire logic                  eop
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Accepted phases, and data phases since the last command
  wire        take    = bus_stb && bus_ready;
  wire        rd_take = take && !bus_we && !cmd_data_select;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  assign cnt_next = cmd_data_select ? 6'h00 : cnt_reg + 6'h01;
  always_ff @(posedge core_clk) begin
    if (rst) cnt_reg <= 6'h00;
    else if (take) cnt_reg <= cnt_next;
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_RD_ANSWER: assert property (rd_take |=> dev_valid)
    else $error("read phase got no data");
  AST_NO_SPURIOUS: assert property (dev_valid |-> $past(rd_take))
    else $error("data returned without a read phase");
  AST_CMD_SILENT: assert property (take && cmd_data_select |=> !dev_valid)
    else $error("command phase returned data");
  AST_EOP_DATA: assert property (eop |-> dev_valid)
    else $error("end of packet without data");
  AST_OE_DATA: assert property (dev_oe_n == !dev_valid)
    else $error("device drive enable not tied to data");
  AST_CMD_DRIVE: assert property (bus_stb && cmd_data_select |-> !host_oe_n)
    else $error("host not driving command code");
  AST_RD_RELEASE: assert property (rd_take |-> host_oe_n)
    else $error("host drives bus during read");
  AST_HOLD: assert property (bus_stb && !bus_ready |=>
    bus_stb && $stable(host_data) && $stable(cmd_data_select))
    else $error("stalled request changed");
  AST_LIMIT: assert property (take && !cmd_data_select |->
    cnt_reg < (bus_wide ? 6'h11 : 6'h22))
    else $error("too many data phases after command");
  // Main scenarios reached
  cover property (eop);
  cover property (take && bus_dma && !cmd_data_select);
  cover property (transfer_end);
endmodule

// >>> verif/endpoint_buffer_access_bench.sv
// Self-checking bench joining the host and device ends
`timescale 1ns/1ps
module endpoint_buffer_access_bench
  import eba_pkg::*;
;
  // Clock, reset, enable and serial engine side
  logic core_clk, rst, ce, usb_buf, usb_rx_done, usb_tx_done, usb_setup;
  logic usb_setup_busy, usb_toggle, stall_set, stall_clr, usb_rd_en;
  logic tx_req, int_clear, u_wide, u_dma, u_cmd_valid, u_wr_valid;
  logic u_rd_valid, u_end, u_ready, u_error, u_rd_data_valid, u_eop;
  logic [3:0]            usb_ep, tx_ep, int_clear_ep;
  logic [EBA_PTR_W-1:0]  usb_rd_ptr;
  logic [7:0]            usb_rd_data, u_cmd;
  logic [EBA_DATA_W-1:0] u_wr_data, u_rd_data;
  int                    failures, checked, errs, i;
  logic [15:0]           rdq[$];
  logic [3:0]            txq[$], icq[$];
  logic                  eopq[$];
  ////////////////////////////////////////////////////////////////////////////
  // Both ends, the bus between them and the checker
  eba_bus_if eba_bus_if_i ();
  eba_device #(.DOUBLE_BUF(16'h0010)) eba_device_i (.*, .bus(eba_bus_if_i));
  eba_host eba_host_i (.*, .bus(eba_bus_if_i));
  eba_props eba_props_i (
    .core_clk(core_clk), .rst(rst), .bus_stb(eba_bus_if_i.bus_stb),
    .bus_we(eba_bus_if_i.bus_we),
    .cmd_data_select(eba_bus_if_i.cmd_data_select),
    .bus_wide(eba_bus_if_i.bus_wide), .bus_dma(eba_bus_if_i.bus_dma),
    .transfer_end(eba_bus_if_i.transfer_end),
    .host_data(eba_bus_if_i.host_data), .host_oe_n(eba_bus_if_i.host_oe_n),
    .bus_ready(eba_bus_if_i.bus_ready), .dev_oe_n(eba_bus_if_i.dev_oe_n),
    .dev_valid(eba_bus_if_i.dev_valid), .eop(eba_bus_if_i.eop));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and output capture away from the edge
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    if (u_rd_data_valid === 1'b1) rdq.push_back(u_rd_data);
    if (u_rd_data_valid === 1'b1) eopq.push_back(u_eop);
    if (tx_req === 1'b1) txq.push_back(tx_ep);
    if (int_clear === 1'b1) icq.push_back(int_clear_ep);
    if (u_error === 1'b1) errs++;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  function automatic logic [7:0] fb(input int k);
    fb = k == 0 ? 8'h20 : (k == 1 ? 8'h00 : 8'h40 + k[7:0]);
  endfunction
  task final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task hs(input logic c, w, r, input logic [7:0] cmd, input logic [15:0] d);
    int n;
    @(posedge core_clk);
    u_cmd_valid <= c;
    u_wr_valid <= w;
    u_rd_valid <= r;
    u_cmd <= cmd;
    u_wr_data <= d;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (u_ready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      final_report();
    end
    @(posedge core_clk);
    {u_cmd_valid, u_wr_valid, u_rd_valid} <= 3'h0;
  endtask
  task await(input int q, input int want);
    int n;
    n = 0;
    while (n < 300 && (q == 0 ? rdq.size() : q == 1 ? txq.size() :
                       icq.size()) < want) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 300) begin
      failures++;
      final_report();
    end
  endtask
  task pulse(input int k, input logic b);
    @(posedge core_clk);
    usb_ep <= 4'h0;
    usb_buf <= b;
    {usb_tx_done, stall_clr, usb_rx_done} <= {k == 5, k == 4, k == 3};
    {usb_toggle, stall_set, usb_setup} <= {k == 2, k == 1, k == 0};
    @(posedge core_clk);
    {usb_tx_done, stall_clr, usb_rx_done, usb_toggle, stall_set} <= 5'h00;
    usb_setup <= 1'b0;
  endtask
  task status(input logic [3:0] ep, input logic [7:0] exp);
    rdq.delete();
    icq.delete();
    hs(1'b1, 1'b0, 1'b0, {4'h5, ep}, 16'h0000);
    hs(1'b0, 1'b0, 1'b1, 8'h00, 16'h0000);
    await(0, 1);
    await(2, 1);
    chk("status", {8'h00, exp}, {8'h00, rdq[0][7:0]});
    chk("int_clear_ep", {12'h000, ep}, {12'h000, icq[0]});
  endtask
  task peek(input logic [3:0] ep, input logic [5:0] p, input logic [7:0] e);
    @(posedge core_clk);
    {usb_ep, usb_buf, usb_rd_en, usb_rd_ptr} <= {ep, 2'b01, p};
    @(posedge core_clk);
    usb_rd_en <= 1'b0;
    @(negedge core_clk);
    chk("usb_rd_data", {8'h00, e}, {8'h00, usb_rd_data});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_fill_send();
    errs = 0;
    hs(1'b1, 1'b0, 1'b0, 8'h02, 16'h0000);
    for (i = 0; i < 34; i++) hs(1'b0, 1'b1, 1'b0, 8'h00, {8'h00, fb(i)});
    hs(1'b0, 1'b1, 1'b0, 8'h00, 16'h00EE);
    await(1, 1);
    chk("tx_ep", 16'h0002, {12'h000, txq[0]});
    chk("u_error", 16'h0001, errs[15:0]);
    peek(4'h2, 6'h00, fb(0));
    peek(4'h2, 6'h21, fb(33));
  endtask
  task t_read_wide();
    @(posedge core_clk);
    u_wide <= 1'b1;
    rdq.delete();
    eopq.delete();
    hs(1'b1, 1'b0, 1'b0, 8'h12, 16'h0000);
    for (i = 0; i < 17; i++) hs(1'b0, 1'b0, 1'b1, 8'h00, 16'h0000);
    await(0, 17);
    for (i = 0; i < 17; i++) begin
      chk("rd_word", {fb(2 * i + 1), fb(2 * i)}, rdq[i]);
      chk("u_eop", {15'h0000, i == 16}, {15'h0000, eopq[i]});
    end
  endtask
  task t_events();
    pulse(1, 1'b0);
    pulse(0, 1'b0);
    pulse(0, 1'b0);
    pulse(2, 1'b0);
    pulse(3, 1'b0);
    pulse(3, 1'b1);
    pulse(1, 1'b0);
    @(posedge core_clk);
    usb_setup_busy <= 1'b1;
    status(4'h0, 8'hFC);
    @(posedge core_clk);
    usb_setup_busy <= 1'b0;
    status(4'h0, 8'hFC);
    status(4'h0, 8'hF4);
    pulse(4, 1'b0);
    pulse(5, 1'b0);
    pulse(2, 1'b0);
    status(4'h0, 8'h44);
  endtask
  task t_dma();
    @(posedge core_clk);
    {u_wide, u_dma} <= 2'b01;
    txq.delete();
    hs(1'b1, 1'b0, 1'b0, 8'h04, 16'h0000);
    for (i = 2; i < 34; i++) hs(1'b0, 1'b1, 1'b0, 8'h00, {8'h00, fb(i)});
    await(1, 1);
    chk("tx_ep", 16'h0004, {12'h000, txq[0]});
    peek(4'h4, 6'h02, fb(2));
    status(4'h4, 8'h22);
    txq.delete();
    errs = 0;
    hs(1'b1, 1'b0, 1'b0, 8'h03, 16'h0000);
    hs(1'b0, 1'b0, 1'b1, 8'h00, 16'h0000);
    for (i = 2; i < 5; i++) hs(1'b0, 1'b1, 1'b0, 8'h00, {8'h00, fb(i)});
    @(posedge core_clk);
    u_end <= 1'b1;
    @(posedge core_clk);
    u_end <= 1'b0;
    await(1, 1);
    chk("tx_ep", 16'h0003, {12'h000, txq[0]});
    chk("u_error", 16'h0001, errs[15:0]);
    peek(4'h3, 6'h04, fb(4));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, ce, usb_ep, usb_rd_ptr, u_cmd, u_wr_data} = {2'b11, 34'h0};
    {usb_buf, usb_rx_done, usb_tx_done, usb_setup, usb_setup_busy} = 5'h00;
    {usb_toggle, stall_set, stall_clr, usb_rd_en} = 4'h0;
    {u_wide, u_dma, u_cmd_valid, u_wr_valid, u_rd_valid, u_end} = 6'h00;
    {failures, checked, errs} = {32'd0, 32'd0, 32'd0};
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 16; i++) status(i[3:0], EBA_ST_RESET);
    t_fill_send();
    t_read_wide();
    t_events();
    t_dma();
    final_report();
  end
endmodule
